// >>> rtl/hsceg_edge_gen.v
// High speed clock edge generator: reset gate, horizontal clocks, strobes, data out
`timescale 1ns/1ps
`default_nettype none
`include "hsceg_regs.vh"

module hsceg_edge_gen #(
  parameter DW = 10
) (
  input wire CLK,
  input wire RST_B,
  input wire REG_WE,
  input wire [7:0] REG_ADDR,
  input wire [5:0] REG_WDATA,
  output reg [5:0] REG_RDATA,
  input wire RG_POL,
  input wire [5:0] RG_POSLOC,
  input wire [5:0] RG_NEGLOC,
  input wire [2:0] RG_DRV,
  input wire HA_POL,
  input wire [5:0] HA_POSLOC,
  input wire [5:0] HA_NEGLOC,
  input wire [2:0] HA_DRV,
  input wire [2:0] HA_INV_DRV,
  input wire HB_POL,
  input wire [5:0] HB_POSLOC,
  input wire [5:0] HB_NEGLOC,
  input wire [2:0] HB_DRV,
  input wire [2:0] HB_INV_DRV,
  input wire [5:0] REF_SAMPLE_POSLOC,
  input wire [5:0] VIDEO_SAMPLE_POSLOC,
  input wire [5:0] DOUT_PHASE,
  input wire [DW-1:0] ADC_DATA,
  output reg RESET_GATE_CLOCK,
  output reg RESET_GATE_CLOCK_OE,
  output reg HORIZ_CLOCK_A,
  output reg HORIZ_CLOCK_A_OE,
  output reg HORIZ_CLOCK_A_INV,
  output reg HORIZ_CLOCK_A_INV_OE,
  output reg HORIZ_CLOCK_B,
  output reg HORIZ_CLOCK_B_OE,
  output reg HORIZ_CLOCK_B_INV,
  output reg HORIZ_CLOCK_B_INV_OE,
  output reg [2:0] RG_DRIVE,
  output reg [2:0] HA_DRIVE,
  output reg [2:0] HA_INV_DRIVE,
  output reg [2:0] HB_DRIVE,
  output reg [2:0] HB_INV_DRIVE,
  output reg REFERENCE_SAMPLE_STROBE,
  output reg VIDEO_SAMPLE_STROBE,
  output reg [DW-1:0] DOUT,
  output reg DOUT_OE,
  output reg [2:0] STEER_MODE,
  output reg PIXEL_GAIN_EN,
  output reg [5:0] PIXEL_PHASE
);

  // ****************************************
  // Edge code to location
  // ****************************************
  // Invalid low nibble yields a location never reached
  function [6:0] edge_loc;
    input [5:0] code;
    begin
      if (code[3:0] > `HSCEG_QUAD_MAX) begin
        edge_loc = `HSCEG_NO_EDGE;
      end else begin
        edge_loc = ({5'h00, code[5:4]} * `HSCEG_QUAD_SIZE)
          + {3'h0, code[3:0]};
      end
    end
  endfunction

  // ****************************************
  // Control-mode register
  // ****************************************
  reg [5:0] ctl;

  always @(posedge CLK) begin
    if (!RST_B) begin
      ctl <= `HSCEG_CTL_RST;
    end else if (REG_WE && REG_ADDR == `HSCEG_CTL_ADDR) begin
      ctl <= REG_WDATA;
    end
  end

  always @(posedge CLK) begin
    if (!RST_B) begin
      REG_RDATA <= 6'h00;
    end else if (REG_ADDR == `HSCEG_CTL_ADDR) begin
      REG_RDATA <= ctl;
    end else begin
      REG_RDATA <= 6'h00;
    end
  end

  // ****************************************
  // Edge position counter
  // ****************************************
  // One clock cycle stands for one edge step
  reg [5:0] phase;
  wire [6:0] phase_x = {1'b0, phase};

  always @(posedge CLK) begin
    if (!RST_B) begin
      phase <= 6'h00;
    end else if (phase == `HSCEG_LAST_STEP) begin
      phase <= 6'h00;
    end else begin
      phase <= phase + 6'h01;
    end
  end

  // ****************************************
  // Programmable edge channels
  // ****************************************
  // Channel 0 reset gate, 1 horizontal A, 2 horizontal B
  wire [17:0] pos_v = {HB_POSLOC, HA_POSLOC, RG_POSLOC};
  wire [17:0] neg_v = {HB_NEGLOC, HA_NEGLOC, RG_NEGLOC};
  wire [2:0] pol_v = {HB_POL, HA_POL, RG_POL};
  reg [2:0] lvl;
  wire [2:0] shaped;

  genvar i;
  generate
    for (i = 0; i < 3; i = i + 1) begin : g_chan
      wire [6:0] rise_loc = edge_loc(pos_v[6*i+5:6*i]);
      wire [6:0] fall_loc = edge_loc(neg_v[6*i+5:6*i]);
      // Rise wins when both codes name the same step
      always @(posedge CLK) begin
        if (!RST_B) begin
          lvl[i] <= 1'b0;
        end else if (phase_x == rise_loc) begin
          lvl[i] <= 1'b1;
        end else if (phase_x == fall_loc) begin
          lvl[i] <= 1'b0;
        end
      end
      assign shaped[i] = lvl[i] ^ pol_v[i];
    end
  endgenerate

  // ****************************************
  // Reset gate output
  // ****************************************
  // Drive code and enable move with the level, one edge behind
  always @(posedge CLK) begin
    if (!RST_B) begin
      RESET_GATE_CLOCK <= 1'b0;
      RESET_GATE_CLOCK_OE <= 1'b0;
      RG_DRIVE <= `HSCEG_DRV_OFF;
    end else begin
      RESET_GATE_CLOCK <= shaped[0];
      RESET_GATE_CLOCK_OE <= (RG_DRV != `HSCEG_DRV_OFF);
      RG_DRIVE <= RG_DRV;
    end
  end

  // ****************************************
  // Horizontal clock A output
  // ****************************************
  // Pin floats while its drive code is zero
  always @(posedge CLK) begin
    if (!RST_B) begin
      HORIZ_CLOCK_A <= 1'b0;
      HORIZ_CLOCK_A_OE <= 1'b0;
      HA_DRIVE <= `HSCEG_DRV_OFF;
    end else begin
      HORIZ_CLOCK_A <= shaped[1];
      HORIZ_CLOCK_A_OE <= (HA_DRV != `HSCEG_DRV_OFF);
      HA_DRIVE <= HA_DRV;
    end
  end

  // ****************************************
  // Horizontal clock A inverse output
  // ****************************************
  // Same shaped level as A, so the pair cross together
  always @(posedge CLK) begin
    if (!RST_B) begin
      HORIZ_CLOCK_A_INV <= 1'b1;
      HORIZ_CLOCK_A_INV_OE <= 1'b0;
      HA_INV_DRIVE <= `HSCEG_DRV_OFF;
    end else begin
      HORIZ_CLOCK_A_INV <= ~shaped[1];
      HORIZ_CLOCK_A_INV_OE <= (HA_INV_DRV != `HSCEG_DRV_OFF);
      HA_INV_DRIVE <= HA_INV_DRV;
    end
  end

  // ****************************************
  // Horizontal clock B output
  // ****************************************
  // Second horizontal pair, same scheme as A
  always @(posedge CLK) begin
    if (!RST_B) begin
      HORIZ_CLOCK_B <= 1'b0;
      HORIZ_CLOCK_B_OE <= 1'b0;
      HB_DRIVE <= `HSCEG_DRV_OFF;
    end else begin
      HORIZ_CLOCK_B <= shaped[2];
      HORIZ_CLOCK_B_OE <= (HB_DRV != `HSCEG_DRV_OFF);
      HB_DRIVE <= HB_DRV;
    end
  end

  // ****************************************
  // Horizontal clock B inverse output
  // ****************************************
  // Complement of B taken from the same level
  always @(posedge CLK) begin
    if (!RST_B) begin
      HORIZ_CLOCK_B_INV <= 1'b1;
      HORIZ_CLOCK_B_INV_OE <= 1'b0;
      HB_INV_DRIVE <= `HSCEG_DRV_OFF;
    end else begin
      HORIZ_CLOCK_B_INV <= ~shaped[2];
      HORIZ_CLOCK_B_INV_OE <= (HB_INV_DRV != `HSCEG_DRV_OFF);
      HB_INV_DRIVE <= HB_INV_DRV;
    end
  end

  // ****************************************
  // Reference sample strobe
  // ****************************************
  // One pulse per pixel period; an invalid code gives none
  wire [6:0] ref_loc = edge_loc(REF_SAMPLE_POSLOC);

  always @(posedge CLK) begin
    if (!RST_B) begin
      REFERENCE_SAMPLE_STROBE <= 1'b0;
    end else begin
      REFERENCE_SAMPLE_STROBE <= (phase_x == ref_loc);
    end
  end

  // ****************************************
  // Video sample strobe
  // ****************************************
  // One pulse per pixel period; an invalid code gives none
  wire [6:0] vid_loc = edge_loc(VIDEO_SAMPLE_POSLOC);

  always @(posedge CLK) begin
    if (!RST_B) begin
      VIDEO_SAMPLE_STROBE <= 1'b0;
    end else begin
      VIDEO_SAMPLE_STROBE <= (phase_x == vid_loc);
    end
  end

  // ****************************************
  // Converter data outputs
  // ****************************************
  wire [6:0] dout_loc = edge_loc(DOUT_PHASE);
  wire dout_edge = (phase_x == dout_loc);

  // Transparent mode copies the converter on every edge
  always @(posedge CLK) begin
    if (!RST_B) begin
      DOUT <= {DW{1'b0}};
    end else if (ctl[`HSCEG_LATCH_BIT] || dout_edge) begin
      DOUT <= ADC_DATA;
    end
  end

  // ****************************************
  // Data output enable
  // ****************************************
  always @(posedge CLK) begin
    if (!RST_B) begin
      DOUT_OE <= 1'b0;
    end else begin
      DOUT_OE <= ~ctl[`HSCEG_TRI_BIT];
    end
  end

  // ****************************************
  // Steering and status
  // ****************************************
  always @(posedge CLK) begin
    if (!RST_B) begin
      STEER_MODE <= 3'h0;
    end else begin
      STEER_MODE <= ctl[`HSCEG_STEER_MSB:`HSCEG_STEER_LSB];
    end
  end

  always @(posedge CLK) begin
    if (!RST_B) begin
      PIXEL_GAIN_EN <= 1'b0;
    end else begin
      PIXEL_GAIN_EN <= ctl[`HSCEG_GAIN_EN_BIT];
    end
  end

  // Counter position as it stood one edge earlier
  always @(posedge CLK) begin
    if (!RST_B) begin
      PIXEL_PHASE <= 6'h00;
    end else begin
      PIXEL_PHASE <= phase;
    end
  end

endmodule // hsceg_edge_gen

`default_nettype wire

// >>> rtl/hsceg_regs.vh
// Constants for the high speed clock edge generator
`ifndef HSCEG_REGS_VH
`define HSCEG_REGS_VH

// ****************************************
// Edge grid
// ****************************************
`define HSCEG_STEPS 6'h30
`define HSCEG_LAST_STEP 6'h2f
`define HSCEG_QUAD_SIZE 7'h0c
`define HSCEG_QUAD_MAX 4'hb
`define HSCEG_NO_EDGE 7'h7f

// ****************************************
// Control-mode register
// ****************************************
`define HSCEG_CTL_ADDR 8'h06
`define HSCEG_CTL_RST 6'h00
`define HSCEG_STEER_MSB 2
`define HSCEG_STEER_LSB 0
`define HSCEG_GAIN_EN_BIT 3
`define HSCEG_LATCH_BIT 4
`define HSCEG_TRI_BIT 5
`define HSCEG_DRV_OFF 3'h0

`endif

// >>> bench/hsceg_edge_gen_sva.sv
// Port checker for the clock edge generator
`timescale 1ns/1ps
`default_nettype none
module hsceg_edge_gen_sva (
  input wire logic CLK,
  input wire logic RST_B,
  input wire logic REG_WE,
  input wire logic [7:0] REG_ADDR,
  input wire logic [5:0] REG_WDATA,
  input wire logic [5:0] REG_RDATA,
  input wire logic [2:0] RG_DRV,
  input wire logic RESET_GATE_CLOCK_OE,
  input wire logic [5:0] REF_SAMPLE_POSLOC,
  input wire logic REFERENCE_SAMPLE_STROBE,
  input wire logic HORIZ_CLOCK_A,
  input wire logic HORIZ_CLOCK_A_INV,
  input wire logic HORIZ_CLOCK_B,
  input wire logic HORIZ_CLOCK_B_INV,
  input wire logic DOUT_OE,
  input wire logic [2:0] STEER_MODE,
  input wire logic PIXEL_GAIN_EN,
  input wire logic [5:0] PIXEL_PHASE
);
  // ****
  // Properties
  // ****
  default clocking @(posedge CLK);
  endclocking
  default disable iff (!RST_B);
  function automatic logic [5:0] loc(input logic [5:0] c);
    loc = c[5:4] * 6'd12 + {2'b00, c[3:0]};
  endfunction
  sequence s_wr6;
    REG_WE && REG_ADDR == 8'h06;
  endsequence
  property p_take;
    logic [5:0] d;
    (s_wr6, d = REG_WDATA) |-> ##2 DOUT_OE == !d[5] && STEER_MODE == d[2:0]
      && PIXEL_GAIN_EN == d[3];
  endproperty
  chk_inv_a: assert property (HORIZ_CLOCK_A_INV == !HORIZ_CLOCK_A)
    else $error("inverse a wrong");
  chk_inv_b: assert property (HORIZ_CLOCK_B_INV == !HORIZ_CLOCK_B)
    else $error("inverse b wrong");
  chk_drive_off: assert property (RG_DRV == 3'h0 |=> !RESET_GATE_CLOCK_OE)
    else $error("drive off ignored");
  chk_strobe_pos: assert property (REFERENCE_SAMPLE_STROBE |->
    PIXEL_PHASE == loc($past(REF_SAMPLE_POSLOC))) else $error("strobe misplaced");
  chk_phase_wrap: assert property (PIXEL_PHASE == 6'h2f |=> PIXEL_PHASE == 6'h00)
    else $error("phase wrap wrong");
  chk_phase_step: assert property ($past(RST_B) && PIXEL_PHASE inside {[6'h01:6'h2e]}
    |=> PIXEL_PHASE == $past(PIXEL_PHASE) + 6'h01) else $error("phase step wrong");
  chk_ctl_take: assert property (p_take)
    else $error("control write lost");
  chk_rd_zero: assert property (REG_ADDR != 8'h06 |=> REG_RDATA == 6'h00)
    else $error("unmapped read not zero");
endmodule // hsceg_edge_gen_sva
bind hsceg_edge_gen hsceg_edge_gen_sva i_hsceg_edge_gen_sva (.CLK, .RST_B, .REG_WE, .REG_ADDR,
  .REG_WDATA, .REG_RDATA, .RG_DRV, .RESET_GATE_CLOCK_OE, .REF_SAMPLE_POSLOC,
  .REFERENCE_SAMPLE_STROBE, .HORIZ_CLOCK_A, .HORIZ_CLOCK_A_INV, .HORIZ_CLOCK_B,
  .HORIZ_CLOCK_B_INV, .DOUT_OE, .STEER_MODE, .PIXEL_GAIN_EN, .PIXEL_PHASE);
`default_nettype wire

// >>> bench/hsceg_ccd_model.sv
// Sensor and sampler model feeding converter data
`timescale 1ns/1ps
`default_nettype none
module hsceg_ccd_model (
  input wire logic CLK,
  input wire logic RST_B,
  input wire logic VIDEO_SAMPLE_STROBE,
  output logic [9:0] ADC_DATA
);
  // New conversion on every master clock cycle
  always @(posedge CLK) begin
    if (!RST_B) begin
      ADC_DATA <= 10'h000;
    end else begin
      ADC_DATA <= ADC_DATA + (VIDEO_SAMPLE_STROBE ? 10'h041 : 10'h001);
    end
  end
endmodule // hsceg_ccd_model
`default_nettype wire

// >>> bench/tb_top.sv
// Testbench for the clock edge generator
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic CLK = 1'b0, RST_B = 1'b0, REG_WE = 1'b0, pl = 1'b0;
  logic [7:0] REG_ADDR = 8'h00;
  logic [5:0] REG_WDATA = 6'h00, ps = 6'h00, ng = 6'h10;
  logic [2:0] dv = 3'h0;
  wire [9:0] ADC_DATA, DOUT;
  wire [5:0] REG_RDATA, PIXEL_PHASE;
  wire [2:0] RG_DRIVE, STEER_MODE;
  wire RESET_GATE_CLOCK, RESET_GATE_CLOCK_OE, HORIZ_CLOCK_A, HORIZ_CLOCK_B_INV;
  wire REFERENCE_SAMPLE_STROBE, VIDEO_SAMPLE_STROBE, DOUT_OE;
  wire HORIZ_CLOCK_A_OE, HORIZ_CLOCK_A_INV, HORIZ_CLOCK_A_INV_OE, HORIZ_CLOCK_B;
  wire HORIZ_CLOCK_B_OE, HORIZ_CLOCK_B_INV_OE, PIXEL_GAIN_EN;
  wire [2:0] HA_DRIVE, HA_INV_DRIVE, HB_DRIVE, HB_INV_DRIVE;
  int err_total = 0, checks_done = 0, cyc = 0, n;
  // Edge codes keep the low nibble at most eleven, quadrant ends included
  logic [12:0] tbl [5] = '{{6'h05, 6'h13, 1'b0}, {6'h2a, 6'h30, 1'b1}, {6'h3b, 6'h00, 1'b0},
    {6'h0b, 6'h1b, 1'b0}, {6'h21, 6'h2b, 1'b1}};
  hsceg_edge_gen i_hsceg_edge_gen (.CLK, .RST_B, .REG_WE, .REG_ADDR, .REG_WDATA, .REG_RDATA,
    .RG_POL(pl), .RG_POSLOC(ps), .RG_NEGLOC(ng), .RG_DRV(dv), .HA_POL(pl), .HA_POSLOC(ps),
    .HA_NEGLOC(ng), .HA_DRV(dv), .HA_INV_DRV(~dv), .HB_POL(pl), .HB_POSLOC(ps), .HB_NEGLOC(ng),
    .HB_DRV(~dv), .HB_INV_DRV(dv), .REF_SAMPLE_POSLOC(ps), .VIDEO_SAMPLE_POSLOC(ng),
    .DOUT_PHASE(ps), .ADC_DATA, .RESET_GATE_CLOCK, .RESET_GATE_CLOCK_OE, .HORIZ_CLOCK_A,
    .HORIZ_CLOCK_A_OE, .HORIZ_CLOCK_A_INV, .HORIZ_CLOCK_A_INV_OE, .HORIZ_CLOCK_B,
    .HORIZ_CLOCK_B_OE, .HORIZ_CLOCK_B_INV, .HORIZ_CLOCK_B_INV_OE, .RG_DRIVE, .HA_DRIVE,
    .HA_INV_DRIVE, .HB_DRIVE, .HB_INV_DRIVE, .REFERENCE_SAMPLE_STROBE,
    .VIDEO_SAMPLE_STROBE, .DOUT, .DOUT_OE, .STEER_MODE, .PIXEL_GAIN_EN, .PIXEL_PHASE);
  hsceg_ccd_model i_hsceg_ccd_model (.CLK, .RST_B, .VIDEO_SAMPLE_STROBE, .ADC_DATA);
  // ****
  // Tasks
  // ****
  always #2 CLK = ~CLK;
  function automatic int lc(input logic [5:0] c);
    return (c[3:0] > 4'hb) ? 99 : c[5:4] * 12 + c[3:0];
  endfunction
  task automatic finish_test();
    $display("TB: checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic cmp(input string nm, input logic [9:0] e, input logic [9:0] s);
    checks_done++;
    if (s !== e) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [5:0] d);
    @(posedge CLK);
    REG_WE <= 1'b1;
    REG_ADDR <= a;
    REG_WDATA <= d;
    @(posedge CLK);
    REG_WE <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [5:0] e);
    @(posedge CLK);
    REG_ADDR <= a;
    @(posedge CLK);
    #1 cmp("rdata", {4'h0, e}, {4'h0, REG_RDATA});
  endtask
  task automatic pixel(output int nch);
    logic [9:0] dp;
    int q, r, f, lv;
    nch = 0;
    repeat (100) @(posedge CLK);
    r = lc(ps);
    f = lc(ng);
    #1 dp = DOUT;
    repeat (48) begin
      @(posedge CLK);
      #1 q = (PIXEL_PHASE + 47) % 48;
      lv = (r == 99) ? 0 : (f == 99 || r == f) ? 1 :
        (r < f) ? (q >= r && q < f) : (q >= r || q < f);
      cmp("rg", lv ^ pl, RESET_GATE_CLOCK);
      cmp("ha", lv ^ pl, HORIZ_CLOCK_A);
      cmp("hb_inv", !(lv ^ pl), HORIZ_CLOCK_B_INV);
      cmp("ha_inv", !(lv ^ pl), HORIZ_CLOCK_A_INV);
      cmp("hb", lv ^ pl, HORIZ_CLOCK_B);
      cmp("ref", PIXEL_PHASE == r, REFERENCE_SAMPLE_STROBE);
      cmp("video", PIXEL_PHASE == f, VIDEO_SAMPLE_STROBE);
      nch += (DOUT !== dp);
      dp = DOUT;
    end
  endtask
  // ****
  // Tests
  // ****
  always @(posedge CLK) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      err_total++;
      finish_test();
    end
  end
  initial begin
    repeat (12) @(posedge CLK);
    RST_B <= 1'b1;
    rd(8'h06, 6'h00);
    for (int i = 0; i < 8; i++) begin
      @(posedge CLK);
      dv <= 3'(i);
      wr(8'h06, 6'(i * 9));
      rd(8'h06, 6'(i * 9));
      cmp("steer", i, STEER_MODE);
      cmp("dout_oe", i < 4, DOUT_OE);
      cmp("rg_drive", i, RG_DRIVE);
      cmp("rg_oe", i > 0, RESET_GATE_CLOCK_OE);
      cmp("gain_en", i % 2, PIXEL_GAIN_EN);
      cmp("ha_drive", i, HA_DRIVE);
      cmp("ha_inv_drive", 7 - i, HA_INV_DRIVE);
      cmp("hb_drive", 7 - i, HB_DRIVE);
      cmp("hb_inv_drive", i, HB_INV_DRIVE);
      cmp("ha_oe", i > 0, HORIZ_CLOCK_A_OE);
      cmp("ha_inv_oe", i < 7, HORIZ_CLOCK_A_INV_OE);
      cmp("hb_oe", i < 7, HORIZ_CLOCK_B_OE);
      cmp("hb_inv_oe", i > 0, HORIZ_CLOCK_B_INV_OE);
    end
    wr(8'h07, 6'h00);
    rd(8'h06, 6'h3f);
    rd(8'h07, 6'h00);
    wr(8'h06, 6'h00);
    $display("TEST registers done");
    foreach (tbl[k]) begin
      @(posedge CLK);
      {ps, ng, pl} <= tbl[k];
      pixel(n);
      cmp("dout_latch", lc(ps) != 99, n);
    end
    $display("TEST edges done");
    wr(8'h06, 6'h10);
    pixel(n);
    cmp("dout_open", 48, n);
    $display("TEST transparent done");
    finish_test();
  end
endmodule // tb_top
`default_nettype wire
